// ### rtl/dacaux_pkg.sv
// Purpose: constants and carrier types for the auxiliary register and read-back block
// Assumes: 24-bit serial frames, MSB first, 50 MHz core clock
// Notes: one home for every offset, field position, reset value and timing count
package dacaux_pkg;

	// frame layout
	localparam int FRAME_BITS = 24;
	localparam int RW_BIT = 23;
	localparam int DEV_HI = 22;
	localparam int DEV_LO = 21;
	localparam int RSEL_HI = 20;
	localparam int RSEL_LO = 16;
	localparam int CHAN_HI = 17;
	localparam int CHAN_LO = 16;
	localparam int CREG_HI = 15;
	localparam int CREG_LO = 13;
	localparam int OUT_PAD_BITS = 8;

	// register select patterns
	localparam logic [2:0] CREG_SWCMD = 3'h4;
	localparam logic [2:0] CREG_BOOST = 3'h3;
	localparam logic [2:0] CREG_SLEW = 3'h0;

	// software command fields
	localparam int KEY_HI = 11;
	localparam int KEY_LO = 0;
	localparam logic [11:0] KEY_RESET = 12'h555;
	localparam logic [11:0] KEY_ALIVE = 12'h195;
	localparam int TOGGLE_BIT = 12;
	localparam int STATUS_TOGGLE_POS = 11;

	// boost converter control fields
	localparam int PHASE_HI = 5;
	localparam int PHASE_LO = 4;
	localparam int FREQ_HI = 3;
	localparam int FREQ_LO = 2;
	localparam int VLIM_HI = 1;
	localparam int VLIM_LO = 0;

	// slew control fields
	localparam int SLEW_EN_BIT = 12;
	localparam int SLEW_RATE_HI = 6;
	localparam int SLEW_RATE_LO = 3;
	localparam int SLEW_STEP_HI = 2;
	localparam int SLEW_STEP_LO = 0;

	// read-back select codes
	localparam logic [4:0] RD_DATA = 5'h00;
	localparam logic [4:0] RD_CTRL = 5'h04;
	localparam logic [4:0] RD_GAIN = 5'h08;
	localparam logic [4:0] RD_OFFS = 5'h0C;
	localparam logic [4:0] RD_CLR = 5'h10;
	localparam logic [4:0] RD_SLEW = 5'h14;
	localparam logic [4:0] RD_STATUS = 5'h18;
	localparam logic [4:0] RD_MAIN = 5'h19;
	localparam logic [4:0] RD_BOOST = 5'h1A;

	// reset values
	localparam logic [5:0] BOOST_RESET = 6'h00;
	localparam logic [7:0] SLEW_RESET = 8'h00;
	localparam logic TOGGLE_RESET = 1'b0;

	// timing
	localparam int CLK_HZ = 50000000;
	localparam int WD_MS_0 = 5;
	localparam int WD_MS_1 = 10;
	localparam int WD_MS_2 = 100;
	localparam int WD_MS_3 = 200;
	localparam int WD_CYC_0 = (CLK_HZ / 1000) * WD_MS_0;
	localparam int WD_CYC_1 = (CLK_HZ / 1000) * WD_MS_1;
	localparam int WD_CYC_2 = (CLK_HZ / 1000) * WD_MS_2;
	localparam int WD_CYC_3 = (CLK_HZ / 1000) * WD_MS_3;
	localparam int WD_CNT_W = 24;

	typedef struct packed {
		logic [1:0] boost_phase_select;
		logic [1:0] boost_switch_rate;
		logic [1:0] boost_voltage_limit;
	} dacaux_boost_t;

	typedef struct packed {
		logic slew_limit_enable;
		logic [3:0] slew_update_rate;
		logic [2:0] slew_step_size;
	} dacaux_slew_t;

	typedef struct packed {
		logic [3:0][15:0] data;
		logic [3:0][15:0] ctrl;
		logic [3:0][15:0] gain;
		logic [3:0][15:0] offs;
		logic [3:0][15:0] clr;
		logic [15:0] status;
		logic [15:0] main_ctrl;
	} dacaux_rb_t;

	typedef enum logic [2:0] {
		DACAUX_WD_OFF = 3'h1,
		DACAUX_WD_RUN = 3'h2,
		DACAUX_WD_FAULT = 3'h4
	} dacaux_wd_t;

endpackage

// ### rtl/dacaux_sync.sv
// Purpose: two-stage synchroniser for levels entering the core clock domain
// Assumes: inputs are levels or toggles held far longer than two clock periods
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
module dacaux_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

// ### rtl/dacaux_top.sv
// Purpose: serial command decode for software command, boost control, slew control and read-back
// Assumes: sclk idles low; sdi changes after rising edges and is taken on falling edges
// Notes: frame word and read-back word are quasi-static across domains; only the frame word is guarded by a toggle, the read-back word by the frame gap
`timescale 1ns/1ps
module dacaux_top
	import dacaux_pkg::*;
#(
	parameter int WD_CYCLES_0 = dacaux_pkg::WD_CYC_0,
	parameter int WD_CYCLES_1 = dacaux_pkg::WD_CYC_1,
	parameter int WD_CYCLES_2 = dacaux_pkg::WD_CYC_2,
	parameter int WD_CYCLES_3 = dacaux_pkg::WD_CYC_3
) (
	// core clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// serial link
	input wire logic sclk,
	input wire logic sync_b,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	// device address pins
	input wire logic [1:0] dev_addr,
	// neighbouring register values for read-back and watchdog control
	input wire dacaux_pkg::dacaux_rb_t rb_regs,
	input wire logic watchdog_enable_bit,
	input wire logic [1:0] watchdog_period,
	// controls to the converter
	output dacaux_pkg::dacaux_boost_t boost_ctrl,
	output dacaux_pkg::dacaux_slew_t [3:0] slew_ctrl,
	output logic user_toggle,
	output logic soft_reset,
	output logic alert
);

	import dacaux_pkg::*;

	// link side: shift in on falling sclk
	logic link_clr;
	logic [4:0] bit_cnt_q;
	logic [FRAME_BITS-2:0] in_sh_q;
	logic [FRAME_BITS-1:0] frame_word_q;
	logic frame_tgl_q;
	wire frame_done = (bit_cnt_q == 5'(FRAME_BITS - 1));

	// frame gap doubles as the link reset; sclk stands still there anyway
	assign link_clr = sync_b | ~rst_b;

	always_ff @(negedge sclk or posedge link_clr) begin
		if (link_clr) begin
			bit_cnt_q <= '0;
			in_sh_q <= '0;
		end else begin
			in_sh_q <= {in_sh_q[FRAME_BITS-3:0], sdi};
			if (bit_cnt_q != 5'(FRAME_BITS))
				bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	// captured word survives the frame gap; extra bits past 24 are dropped
	// a frame cut short never reaches frame_done and leaves no trace
	always_ff @(negedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			frame_word_q <= '0;
			frame_tgl_q <= 1'b0;
		end else if (frame_done) begin
			frame_word_q <= {in_sh_q, sdi};
			frame_tgl_q <= ~frame_tgl_q;
		end
	end

	// link side: shift out on rising sclk
	logic [15:0] rdata_q;
	logic loaded_q;
	logic [FRAME_BITS-2:0] out_sh_q;
	logic sdo_q;
	logic sdo_oe_q;
	wire [FRAME_BITS-1:0] out_word = {{OUT_PAD_BITS{1'b0}}, rdata_q};

	// rdata_q settled during the previous frame gap, so it is stable here
	always_ff @(posedge sclk or posedge link_clr) begin
		if (link_clr) begin
			loaded_q <= 1'b0;
			out_sh_q <= '0;
			sdo_q <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else begin
			loaded_q <= 1'b1;
			sdo_oe_q <= 1'b1;
			if (!loaded_q) begin
				{sdo_q, out_sh_q} <= out_word;
			end else begin
				{sdo_q, out_sh_q} <= {out_sh_q, 1'b0};
			end
		end
	end

	assign sdo = sdo_q;
	assign sdo_oe = sdo_oe_q;

	// core side: reset release and crossings
	// address pins are static straps, so a plain two-flop copy is enough
	logic rst_sync;
	logic ftgl_s;
	logic ftgl_seen_q;
	logic [1:0] addr_s;

	dacaux_sync #(.W(1)) u_rst_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d(1'b1),
		.q(rst_sync)
	);

	dacaux_sync #(.W(1)) u_frame_sync (
		.clk(clk),
		.rst_b(rst_sync),
		.d(frame_tgl_q),
		.q(ftgl_s)
	);

	dacaux_sync #(.W(2)) u_addr_sync (
		.clk(clk),
		.rst_b(rst_sync),
		.d(dev_addr),
		.q(addr_s)
	);

	// frame decode
	wire frame_ev = ftgl_s ^ ftgl_seen_q;
	wire addr_hit = (frame_word_q[DEV_HI:DEV_LO] == addr_s);
	wire frame_ok = frame_ev & addr_hit;
	wire is_read = frame_word_q[RW_BIT];
	wire [2:0] creg = frame_word_q[CREG_HI:CREG_LO];
	wire [11:0] key = frame_word_q[KEY_HI:KEY_LO];
	wire [1:0] chan = frame_word_q[CHAN_HI:CHAN_LO];
	wire [4:0] rsel = frame_word_q[RSEL_HI:RSEL_LO];
	wire wr_ok = frame_ok & ~is_read;
	wire swcmd_wr = wr_ok & (creg == CREG_SWCMD);
	wire boost_wr = wr_ok & (creg == CREG_BOOST);
	wire slew_wr = wr_ok & (creg == CREG_SLEW);
	wire reset_key = swcmd_wr & (key == KEY_RESET);
	wire alive_key = swcmd_wr & (key == KEY_ALIVE);

	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync)
			ftgl_seen_q <= 1'b0;
		else
			ftgl_seen_q <= ftgl_s;
	end

	// software command effects
	logic toggle_q;
	logic soft_reset_q;

	// a reset write still takes its own toggle bit, since reset_key never clears toggle_q
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			toggle_q <= TOGGLE_RESET;
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= reset_key;
			if (swcmd_wr)
				toggle_q <= frame_word_q[TOGGLE_BIT];
		end
	end

	// boost converter control
	logic [5:0] boost_q;
	wire [5:0] boost_wdata = {frame_word_q[PHASE_HI:PHASE_LO], frame_word_q[FREQ_HI:FREQ_LO],
		frame_word_q[VLIM_HI:VLIM_LO]};

	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync)
			boost_q <= BOOST_RESET;
		else if (reset_key)
			boost_q <= BOOST_RESET;
		else if (boost_wr)
			boost_q <= boost_wdata;
	end

	// per-channel slew control
	logic [3:0][7:0] slew_q;
	wire [7:0] slew_wdata = {frame_word_q[SLEW_EN_BIT], frame_word_q[SLEW_RATE_HI:SLEW_RATE_LO],
		frame_word_q[SLEW_STEP_HI:SLEW_STEP_LO]};

	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			slew_q <= {4{SLEW_RESET}};
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (reset_key)
					slew_q[i] <= SLEW_RESET;
				else if (slew_wr && (chan == 2'(i)))
					slew_q[i] <= slew_wdata;
			end
		end
	end

	// read-back selection
	function automatic logic [15:0] slew_word(input logic [7:0] s);
		slew_word = {3'h0, s[7], 5'h00, s[6:0]};
	endfunction

	logic [15:0] rb_val;
	wire [1:0] rsel_ch = rsel[1:0];
	wire [15:0] status_val = {rb_regs.status[15:STATUS_TOGGLE_POS+1], toggle_q,
		rb_regs.status[STATUS_TOGGLE_POS-1:0]};
	wire [15:0] boost_val = {10'h000, boost_q};

	always_comb begin
		rb_val = 16'h0000;
		unique case (rsel[4:2])
			3'h0: rb_val = rb_regs.data[rsel_ch];
			3'h1: rb_val = rb_regs.ctrl[rsel_ch];
			3'h2: rb_val = rb_regs.gain[rsel_ch];
			3'h3: rb_val = rb_regs.offs[rsel_ch];
			3'h4: rb_val = rb_regs.clr[rsel_ch];
			3'h5: rb_val = slew_word(slew_q[rsel_ch]);
			3'h6: begin
				if (rsel == RD_STATUS)
					rb_val = status_val;
				else if (rsel == RD_MAIN)
					rb_val = rb_regs.main_ctrl;
				else if (rsel == RD_BOOST)
					rb_val = boost_val;
				else
					rb_val = 16'h0000;
			end
			3'h7: rb_val = 16'h0000;
		endcase
	end

	// any addressed frame other than a read leaves zeros for the next transfer
	// limitation: the next frame must wait for this load, three core clock edges after the last falling sclk
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync)
			rdata_q <= 16'h0000;
		else if (frame_ok)
			rdata_q <= is_read ? rb_val : 16'h0000;
	end

	// watchdog
	// fault stands until a key, a disable or a soft reset; it never clears itself
	function automatic logic [WD_CNT_W-1:0] wd_load(input logic [1:0] sel);
		unique case (sel)
			2'h0: wd_load = WD_CNT_W'(WD_CYCLES_0 - 1);
			2'h1: wd_load = WD_CNT_W'(WD_CYCLES_1 - 1);
			2'h2: wd_load = WD_CNT_W'(WD_CYCLES_2 - 1);
			2'h3: wd_load = WD_CNT_W'(WD_CYCLES_3 - 1);
		endcase
	endfunction

	dacaux_wd_t wd_state_q;
	dacaux_wd_t wd_state_d;
	logic [WD_CNT_W-1:0] wd_cnt_q;
	logic [WD_CNT_W-1:0] wd_cnt_d;
	logic alert_q;
	wire [WD_CNT_W-1:0] wd_full = wd_load(watchdog_period);
	wire wd_zero = (wd_cnt_q == '0);

	// the host keeps its own keep-alive cadence; we only time it
	always_comb begin
		wd_state_d = wd_state_q;
		wd_cnt_d = wd_cnt_q;
		unique case (wd_state_q)
			DACAUX_WD_OFF: begin
				wd_cnt_d = wd_full;
				if (watchdog_enable_bit)
					wd_state_d = DACAUX_WD_RUN;
			end
			DACAUX_WD_RUN: begin
				if (!watchdog_enable_bit) begin
					wd_state_d = DACAUX_WD_OFF;
				end else if (alive_key) begin
					wd_cnt_d = wd_full;
				end else if (wd_zero) begin
					wd_state_d = DACAUX_WD_FAULT;
				end else begin
					wd_cnt_d = wd_cnt_q - 1'b1;
				end
			end
			DACAUX_WD_FAULT: begin
				if (!watchdog_enable_bit) begin
					wd_state_d = DACAUX_WD_OFF;
				end else if (alive_key) begin
					wd_state_d = DACAUX_WD_RUN;
					wd_cnt_d = wd_full;
				end
			end
			default: begin
				wd_state_d = DACAUX_WD_OFF;
				wd_cnt_d = wd_full;
			end
		endcase
		if (reset_key) begin
			wd_state_d = DACAUX_WD_OFF;
			wd_cnt_d = wd_full;
		end
	end

	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			wd_state_q <= DACAUX_WD_OFF;
			wd_cnt_q <= '0;
			alert_q <= 1'b0;
		end else begin
			wd_state_q <= wd_state_d;
			wd_cnt_q <= wd_cnt_d;
			alert_q <= (wd_state_d == DACAUX_WD_FAULT);
		end
	end

	// outputs
	// every output below is a flop, no logic after the registers
	assign boost_ctrl = boost_q;
	assign slew_ctrl = slew_q;
	assign user_toggle = toggle_q;
	assign soft_reset = soft_reset_q;
	assign alert = alert_q;

endmodule

// ### tb/dacaux_host.sv
// Purpose: host model driving the serial link
// Assumes: sclk idles low, sdi moves after rising edges
// Notes: edges sit 7 ns off the core clock grid
`timescale 1ns/1ps
module dacaux_host (
	// link
	output logic sclk,
	output logic sync_b,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sclk = 1'b0;
		sync_b = 1'b1;
		sdi = 1'b0;
	end
	// one whole frame msb first, sdo taken on falling edges
	task automatic xfer(input logic [23:0] w, output logic [23:0] r);
		#7;
		sync_b = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			#20 sclk = 1'b1;
			sdi = w[i];
			#40 sclk = 1'b0;
			r[i] = sdo;
			#20;
		end
		#20 sync_b = 1'b1;
		// released line flips so no stale bit is trusted
		sdi = ~sdi;
		#400;
	endtask
endmodule

// ### tb/dacaux_top_assertions.sv
// Purpose: port checks for the auxiliary register block
// Assumes: bound to dacaux_top
// Notes: alert timing is a lower bound only
`timescale 1ns/1ps
module dacaux_top_assertions
	import dacaux_pkg::*;
#(
	parameter int WD_CYCLES_0 = 50
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// link
	input wire logic sync_b,
	input wire logic sdo,
	input wire logic sdo_oe,
	// controls
	input wire logic watchdog_enable_bit,
	input wire dacaux_pkg::dacaux_boost_t boost_ctrl,
	input wire dacaux_pkg::dacaux_slew_t [3:0] slew_ctrl,
	input wire logic user_toggle,
	input wire logic soft_reset,
	input wire logic alert
);
	int quiet_q;
	int quiet_d;
	// restarts on any alert, so a late key only lengthens the wait
	assign quiet_d = (!watchdog_enable_bit || alert) ? 0 : quiet_q + 1;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			quiet_q <= 0;
		end else begin
			quiet_q <= quiet_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_sdo_idle;
		sync_b && $past(sync_b) |-> !sdo && !sdo_oe;
	endproperty
	a_sdo_idle: assert property (p_sdo_idle) else $error("sdo busy when idle");
	property p_oe_frame;
		sdo_oe |-> !sync_b;
	endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("sdo_oe outside frame");
	property p_pulse;
		soft_reset |=> !soft_reset;
	endproperty
	a_pulse: assert property (p_pulse) else $error("soft_reset too long");
	property p_rst_clears;
		soft_reset |-> ##[0:2] (boost_ctrl == BOOST_RESET && slew_ctrl == '0);
	endproperty
	a_rst_clears: assert property (p_rst_clears) else $error("soft reset left state");
	property p_boost_quiet;
		!$stable(boost_ctrl) |-> sync_b;
	endproperty
	a_boost_quiet: assert property (p_boost_quiet) else $error("boost moved in frame");
	property p_slew_quiet;
		!$stable(slew_ctrl) |-> sync_b;
	endproperty
	a_slew_quiet: assert property (p_slew_quiet) else $error("slew moved in frame");
	property p_toggle_quiet;
		!$stable(user_toggle) |-> sync_b;
	endproperty
	a_toggle_quiet: assert property (p_toggle_quiet) else $error("toggle moved in frame");
	property p_alert_en;
		!watchdog_enable_bit [*3] |-> !alert;
	endproperty
	a_alert_en: assert property (p_alert_en) else $error("alert while disabled");
	property p_alert_wait;
		$rose(alert) |-> quiet_q >= WD_CYCLES_0;
	endproperty
	a_alert_wait: assert property (p_alert_wait) else $error("alert too early");
endmodule
bind dacaux_top dacaux_top_assertions #(.WD_CYCLES_0(WD_CYCLES_0)) dacaux_top_assertions_inst (
	.clk(clk), .rst_b(rst_b), .sync_b(sync_b), .sdo(sdo), .sdo_oe(sdo_oe),
	.watchdog_enable_bit(watchdog_enable_bit), .boost_ctrl(boost_ctrl), .slew_ctrl(slew_ctrl),
	.user_toggle(user_toggle), .soft_reset(soft_reset), .alert(alert));

// ### tb/tb.sv
// Purpose: self-checking bench for the auxiliary register block
// Assumes: short watchdog periods
// Notes: expected state kept in boost_e and slew_e
`timescale 1ns/1ps
module tb;
	import dacaux_pkg::*;
	localparam int WD0 = 300;
	logic clk, rst_b, sclk, sync_b, sdi, sdo, sdo_oe, wd_en, user_toggle, soft_reset, alert;
	logic [1:0] dev_addr, wd_per;
	logic [23:0] rx;
	logic [5:0] boost_e;
	logic [3:0][7:0] slew_e;
	dacaux_rb_t rb;
	dacaux_boost_t boost;
	dacaux_slew_t [3:0] slew;
	int n_errors = 0;
	int checked = 0;
	int n_pulse = 0;
	dacaux_top #(.WD_CYCLES_0(WD0), .WD_CYCLES_1(2 * WD0), .WD_CYCLES_2(4 * WD0), .WD_CYCLES_3(8 * WD0))
	dacaux_top_inst (.clk(clk), .rst_b(rst_b), .sclk(sclk), .sync_b(sync_b), .sdi(sdi), .sdo(sdo),
		.sdo_oe(sdo_oe), .dev_addr(dev_addr), .rb_regs(rb), .watchdog_enable_bit(wd_en),
		.watchdog_period(wd_per), .boost_ctrl(boost), .slew_ctrl(slew), .user_toggle(user_toggle),
		.soft_reset(soft_reset), .alert(alert));
	dacaux_host dacaux_host_inst (.sclk(sclk), .sync_b(sync_b), .sdi(sdi), .sdo(sdo));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (soft_reset === 1'b1) begin
			n_pulse++;
		end
	end
	task automatic end_of_test;
		$display("errors %0d checked %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task automatic frame(input logic [23:0] w);
		@(posedge clk);
		dacaux_host_inst.xfer(w, rx);
	endtask
	task automatic wr(input logic [2:0] sel, input logic [12:0] d, input logic [1:0] ch);
		frame({1'b0, dev_addr, 3'h0, ch, sel, d});
	endtask
	task automatic rd(input logic [4:0] c, input logic [1:0] a);
		frame({1'b1, a, c, 16'hFFFF});
	endtask
	function automatic logic [15:0] ev(input logic [4:0] c);
		case (c[4:2])
			3'h0: ev = rb.data[c[1:0]];
			3'h1: ev = rb.ctrl[c[1:0]];
			3'h2: ev = rb.gain[c[1:0]];
			3'h3: ev = rb.offs[c[1:0]];
			3'h4: ev = rb.clr[c[1:0]];
			3'h5: ev = {3'h0, slew_e[c[1:0]][7], 5'h0, slew_e[c[1:0]][6:0]};
			default: ev = c == 5'h18 ? rb.status : c == 5'h19 ? rb.main_ctrl : c == 5'h1A ? {10'h0, boost_e} : 16'h0;
		endcase
	endfunction
	task automatic t_boost;
		for (int i = 0; i < 4; i++) begin
			boost_e = {i[1:0], ~i[1:0], i[1:0]};
			wr(CREG_BOOST, {7'h7F, boost_e}, 2'h0);
			chk("boost", {10'h0, boost_e}, {10'h0, boost});
		end
		frame({1'b0, ~dev_addr, 5'h0, CREG_BOOST, 13'h0});
		wr(3'h1, 13'h0, 2'h0);
		chk("boost kept", {10'h0, boost_e}, {10'h0, boost});
	endtask
	task automatic t_slew;
		for (int c = 0; c < 4; c++) begin
			slew_e[c] = {c[0], 4'(c + 9), 3'(c + 1)};
			wr(CREG_SLEW, {c[0], 5'h1F, 4'(c + 9), 3'(c + 1)}, c[1:0]);
		end
		for (int c = 0; c < 4; c++) begin
			chk("slew", {8'h0, slew_e[c]}, {8'h0, slew[c]});
		end
	endtask
	task automatic t_read;
		rd(5'h00, dev_addr);
		for (int c = 1; c < 33; c++) begin
			rd(5'(c), dev_addr);
			chk("readback", ev(5'(c - 1)), rx[15:0]);
			chk("pad", 16'h0, {8'h0, rx[23:16]});
		end
		rd(5'h08, ~dev_addr);
		chk("foreign", ev(5'h00), rx[15:0]);
		rd(5'h09, dev_addr);
		chk("kept", ev(5'h00), rx[15:0]);
	endtask
	task automatic t_soft;
		int n0;
		n0 = n_pulse;
		wr(CREG_SWCMD, {1'b1, 12'h123}, 2'h0);
		chk("toggle", 16'h1, {15'h0, user_toggle});
		rd(RD_STATUS, dev_addr);
		rd(RD_STATUS, dev_addr);
		chk("status", {rb.status[15:12], 1'b1, rb.status[10:0]}, rx[15:0]);
		wr(CREG_SWCMD, 13'h0, 2'h0);
		chk("toggle", 16'h0, {15'h0, user_toggle});
		rd(RD_STATUS, dev_addr);
		rd(RD_STATUS, dev_addr);
		chk("status", {rb.status[15:12], 1'b0, rb.status[10:0]}, rx[15:0]);
		chk("pulses", 16'(n0), 16'(n_pulse));
		wr(CREG_SWCMD, {1'b1, KEY_RESET}, 2'h0);
		chk("pulses", 16'(n0 + 1), 16'(n_pulse));
		chk("boost", 16'h0, {10'h0, boost});
		chk("slew", 16'h0, slew[1:0]);
		chk("slew", 16'h0, slew[3:2]);
		chk("toggle", 16'h1, {15'h0, user_toggle});
	endtask
	task automatic t_wd;
		longint t0;
		int k;
		for (int p = 0; p < 4; p++) begin
			@(posedge clk);
			wd_per <= p[1:0];
			wd_en <= 1'b1;
			wr(CREG_SWCMD, {1'b0, KEY_ALIVE}, 2'h0);
			if (p == 1) begin
				wr(CREG_SWCMD, {1'b0, KEY_ALIVE}, 2'h0);
			end
			t0 = $time;
			if (p == 0) begin
				wr(CREG_SWCMD, {1'b0, 12'h194}, 2'h0);
			end
			k = 0;
			while (alert !== 1'b1 && k < 9 * WD0) begin
				@(posedge clk);
				k++;
			end
			if (k == 9 * WD0) begin
				n_errors++;
				end_of_test();
			end
			k = int'(($time - t0) / 20);
			chk("alert delay", 16'h1, {15'h0, k inside {[(WD0 << p) - 24 : (WD0 << p) + 4]}});
			@(posedge clk);
			wd_en <= 1'b0;
			repeat (4) @(posedge clk);
			chk("alert off", 16'h0, {15'h0, alert});
		end
	endtask
	initial begin
		rst_b = 1'b0;
		dev_addr = 2'h2;
		wd_en = 1'b0;
		wd_per = 2'h0;
		for (int i = 0; i < 4; i++) begin
			rb.data[i] = 16'h1100 + 16'(i);
			rb.ctrl[i] = 16'h2200 + 16'(i);
			rb.gain[i] = 16'h3300 + 16'(i);
			rb.offs[i] = 16'h4400 + 16'(i);
			rb.clr[i] = 16'h5500 + 16'(i);
		end
		rb.status = 16'h0123;
		rb.main_ctrl = 16'h0C5A;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		t_boost();
		t_slew();
		t_read();
		t_soft();
		t_wd();
		end_of_test();
	end
endmodule
